// File: verilog/reset_ctrl_pkg.sv
// Purpose: shared constants and carriers for the peripheral soft reset control block
// Assumes: 32-bit register port, word registers at byte offsets
// Notes: implemented-bit masks define which positions are writable
package reset_ctrl_pkg;

	localparam logic [31:0] sysctl_base = 32'h400f_e000;
	localparam logic [11:0] off_reset_one = 12'h044;
	localparam logic [11:0] off_reset_two = 12'h048;
	localparam logic [31:0] reset_one_init = 32'h0000_0000;
	localparam logic [31:0] reset_two_init = 32'h0000_0000;

	// bit positions, first register
	localparam int pos_timer_two = 18;
	localparam int pos_timer_one = 17;
	localparam int pos_timer_zero = 16;
	localparam int pos_twowire_one = 14;
	localparam int pos_twowire_zero = 12;
	localparam int pos_sync_serial = 4;
	localparam int pos_async_one = 1;
	localparam int pos_async_zero = 0;

	// bit positions, second register
	localparam int pos_usb = 16;
	localparam int pos_micro_dma = 13;
	localparam int pos_port_e = 4;
	localparam int pos_port_a = 0;

	// writable positions
	localparam logic [31:0] impl_mask_one = 32'h0007_5013;
	localparam logic [31:0] impl_mask_two = 32'h0001_201f;

	// per-peripheral reset requests
	typedef struct packed {
		logic gp_timer_two_reset;
		logic gp_timer_one_reset;
		logic gp_timer_zero_reset;
		logic twowire_one_reset;
		logic twowire_zero_reset;
		logic sync_serial_reset;
		logic async_serial_one_reset;
		logic async_serial_zero_reset;
	} reset_group_one_t;

	typedef struct packed {
		logic usb_unit_reset;
		logic micro_dma_reset;
		logic [4:0] port_reset; // e..a
	} reset_group_two_t;

	// register port request
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

endpackage

// File: verilog/masked_reg.sv
// Purpose: one reset control word with capability-masked writes
// Assumes: write strobe one cycle wide
// Notes: unimplemented bits stay zero forever
`timescale 1ns/10ps
module masked_reg
	import reset_ctrl_pkg::*;
#(
	parameter logic [31:0] impl_mask = 32'h0000_0000,
	parameter logic [31:0] init_val = 32'h0000_0000
)
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic wr_en,
	input wire logic [31:0] wdata,
	input wire logic [31:0] cap_mask,
	output logic [31:0] value
);
	logic [31:0] value_q;
	logic [31:0] keep_mask;

	// only present and implemented bits take the write
	assign keep_mask = impl_mask & cap_mask;

	// register update
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			value_q <= init_val;
		else if (wr_en)
			value_q <= (value_q & ~keep_mask) | (wdata & keep_mask);
	end

	assign value = value_q;
endmodule // masked_reg

// File: verilog/periph_reset_ctrl.sv
// Purpose: two software reset control registers driving peripheral resets
// Assumes: plain register port, read data one cycle after read strobe
// Notes: capability masks arrive as inputs from the capability registers
//
// Behaviour
// - first reset register at offset 0x044
// - second reset register at offset 0x048
// - both registers reset to zero
// - writes masked by capability register bits
// - bits 18,17,16 reset timers 2,1,0
// - bit 14 twowire one, 12 twowire zero
// - bit 4 sync serial, 1,0 uarts
// - second register: 16 usb, 13 dma
// - second register bits 4..0 ports e..a
// - reserved bits read zero, read-only
`timescale 1ns/10ps
module periph_reset_ctrl
	import reset_ctrl_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic [11:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic [31:0] capability_mask_two,
	input wire logic [31:0] capability_mask_four,
	output reset_group_one_t resets_one,
	output reset_group_two_t resets_two
);
	reg_req_t req;
	logic [31:0] reg_one;
	logic [31:0] reg_two;
	logic sel_one;
	logic sel_two;
	logic [31:0] rdata_q;
	reset_group_one_t resets_one_q;
	reset_group_two_t resets_two_q;

	// bundle the port
	assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

	// address decode
	assign sel_one = (req.addr == off_reset_one);
	assign sel_two = (req.addr == off_reset_two);

	// first control word
	masked_reg #(
		.impl_mask(impl_mask_one),
		.init_val(reset_one_init)
	) u_reg_one (
		.clock(clock),
		.nrst(nrst),
		.wr_en(req.wr & sel_one),
		.wdata(req.wdata),
		.cap_mask(capability_mask_two),
		.value(reg_one)
	);

	// second control word
	masked_reg #(
		.impl_mask(impl_mask_two),
		.init_val(reset_two_init)
	) u_reg_two (
		.clock(clock),
		.nrst(nrst),
		.wr_en(req.wr & sel_two),
		.wdata(req.wdata),
		.cap_mask(capability_mask_four),
		.value(reg_two)
	);

	// read data, unmapped reads return zero
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			rdata_q <= 32'h0000_0000;
		else if (req.rd)
		begin
			if (sel_one)
				rdata_q <= reg_one;
			else if (sel_two)
				rdata_q <= reg_two;
			else
				rdata_q <= 32'h0000_0000;
		end
		else
			rdata_q <= 32'h0000_0000;
	end

	// peripheral reset outputs, registered copies of the control bits
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			resets_one_q <= '0;
			resets_two_q <= '0;
		end
		else
		begin
			resets_one_q.gp_timer_two_reset <= reg_one[pos_timer_two];
			resets_one_q.gp_timer_one_reset <= reg_one[pos_timer_one];
			resets_one_q.gp_timer_zero_reset <= reg_one[pos_timer_zero];
			resets_one_q.twowire_one_reset <= reg_one[pos_twowire_one];
			resets_one_q.twowire_zero_reset <= reg_one[pos_twowire_zero];
			resets_one_q.sync_serial_reset <= reg_one[pos_sync_serial];
			resets_one_q.async_serial_one_reset <= reg_one[pos_async_one];
			resets_one_q.async_serial_zero_reset <= reg_one[pos_async_zero];
			resets_two_q.usb_unit_reset <= reg_two[pos_usb];
			resets_two_q.micro_dma_reset <= reg_two[pos_micro_dma];
			resets_two_q.port_reset <= reg_two[pos_port_e:pos_port_a];
		end
	end

	assign rdata = rdata_q;
	assign resets_one = resets_one_q;
	assign resets_two = resets_two_q;
endmodule // periph_reset_ctrl

// File: verification/periph_reset_ctrl_checker.sv
// Purpose: port checks
// Assumes: outputs lag bits one cycle
// Notes: bound below
`timescale 1ns/10ps
module periph_reset_ctrl_checker
	import reset_ctrl_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic wr,
	input wire logic rd,
	input wire logic [11:0] addr,
	input wire logic [31:0] wdata,
	input wire logic [31:0] rdata,
	input wire logic [31:0] capability_mask_two,
	input wire logic [31:0] capability_mask_four,
	input wire reset_group_one_t resets_one,
	input wire reset_group_two_t resets_two
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!nrst);
	// reads of each word
	sequence s_r1; rd && addr == off_reset_one; endsequence
	sequence s_r2; rd && addr == off_reset_two; endsequence
	property p_init; $rose(nrst) |-> !{resets_one, resets_two}; endproperty
	property p_w1; wr && addr == off_reset_one && capability_mask_two[0]
		|-> ##2 resets_one[0] == $past(wdata[0], 2); endproperty
	property p_w2; wr && addr == off_reset_two && !capability_mask_four[4] |-> ##2 $stable(resets_two[4]); endproperty
	property p_r1; s_r1 |=> rdata[0] == resets_one[0] && !rdata[3:2]; endproperty
	property p_r2; s_r2 |=> rdata[16] == resets_two[6] && !rdata[31:17]; endproperty
	property p_un; rd && addr[3:0] == 4'hc |=> !rdata; endproperty
	property p_idle; !rd |=> !rdata; endproperty
	property p_hold; !wr [*2] |=> $stable({resets_one, resets_two}); endproperty
	a_init: assert property (p_init) else $error("init");
	a_w1: assert property (p_w1) else $error("w1");
	a_w2: assert property (p_w2) else $error("w2");
	a_r1: assert property (p_r1) else $error("r1");
	a_r2: assert property (p_r2) else $error("r2");
	a_un: assert property (p_un) else $error("un");
	a_idle: assert property (p_idle) else $error("idle");
	a_hold: assert property (p_hold) else $error("hold");
endmodule // periph_reset_ctrl_checker
bind periph_reset_ctrl periph_reset_ctrl_checker chk_i (.*);

// File: verification/periph_reset_ctrl_bench.sv
// Purpose: bench
// Assumes: rdata one cycle after rd
// Notes: m1 m2 shadow the words
`timescale 1ns/10ps
module periph_reset_ctrl_bench;
	import reset_ctrl_pkg::*;
	logic clock = 0, nrst = 0, wr = 0, rd = 0, rv = 0;
	logic [11:0] addr = 0;
	logic [31:0] wdata = 0, c2 = 0, c4 = 0, m1 = 0, m2 = 0, rdata;
	reset_group_one_t r1;
	reset_group_two_t r2;
	logic [31:0] q[$];
	int fail_count = 0, checked = 0;
	always #2.5 clock = ~clock;
	periph_reset_ctrl DUT (.clock, .nrst, .addr, .wdata, .wr, .rd, .rdata, .capability_mask_two(c2),
		.capability_mask_four(c4), .resets_one(r1), .resets_two(r2));
	task chk(string n, logic [31:0] s, e);
		checked++;
		if (s !== e)
		begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// one strobe, shadow and note updated
	task bus(logic w, logic [11:0] a, logic [31:0] d);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		if (w && a == off_reset_one)
			m1 = m1 & ~(c2 & impl_mask_one) | d & c2 & impl_mask_one;
		if (w && a == off_reset_two)
			m2 = m2 & ~(c4 & impl_mask_two) | d & c4 & impl_mask_two;
		if (!w)
			q.push_back(a == off_reset_one ? m1 : a == off_reset_two ? m2 : 32'h0);
		@(posedge clock);
	endtask
	task idle(int n);
		wr <= 0;
		rd <= 0;
		repeat (n) @(posedge clock);
	endtask
	// compare read data with the oldest note
	always @(posedge clock)
	begin
		rv <= rd;
		if (rv)
			chk("rdata", rdata, q.pop_front());
	end
	// cut a hang short
	initial
	begin
		#100000;
		fail_count++;
		test_done;
	end
	// main sequence, two passes with a reset between
	initial
	begin
		void'($urandom(44356));
		repeat (2) @(posedge clock);
		nrst <= 1;
		for (int r = 0; r < 2; r++)
		begin
			idle(1);
			bus(0, off_reset_one, 0);
			bus(0, off_reset_two, 0);
			for (int i = 0; i < 60; i++)
			begin
				c2 <= i < 4 ? '1 : $urandom;
				c4 <= i < 4 ? '1 : $urandom;
				idle(1);
				bus(1, i[0] ? off_reset_two : off_reset_one, $urandom);
				bus(1, {i[3:0], 8'h4c}, $urandom);
				bus(0, off_reset_one, 0);
				bus(0, off_reset_two, 0);
				bus(0, {i[3:0], 8'h4c}, 0);
				idle(2);
				chk("resets_one", r1, {m1[18:16], m1[14], m1[12], m1[4], m1[1:0]});
				chk("resets_two", r2, {m2[16], m2[13], m2[4:0]});
			end
			$display("pass %0d done", r);
			nrst <= 0;
			idle(1);
			chk("cleared", {r1, r2}, 0);
			m1 = 0;
			m2 = 0;
			nrst <= 1;
		end
		test_done;
	end
endmodule // periph_reset_ctrl_bench
